// ### design/acu_compare_ctrl.v
/*
 * digital control of the analog compare unit: apb register file,
 * input and reference generator steering, comparator output
 * synchroniser, edge flag, interrupt and stop wakeup.
 * assumes an apb master on clk and an analog core that returns a raw,
 * asynchronous comparator output.
 */
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "acu_consts.vh"

module acu_compare_ctrl (
    input wire clk,
    input wire reset,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire compareRaw,
    input wire stopMode,
    output reg compareEnable,
    output reg [2:0] plusInputSelect,
    output reg [2:0] minusInputSelect,
    output reg [6:0] inputPinEnables,
    output reg refGenEnable,
    output reg refSourceSelect,
    output reg [4:0] refLevelCode,
    output reg comparePinOut,
    output reg comparePinOe,
    output reg edgeIrq,
    output reg stopWakeIrq
);

    reg [1:0] edgeSelect_r;
    reg outputPinEnable_r;
    reg edgeIrqEnable_r;
    reg edgeFlag_r;
    reg syncA_r;
    reg syncB_r;
    reg level_r;
    reg prevLevel_r;
    reg [7:0] readByte;
    wire access;
    wire wrEn;
    wire validEdge;
    wire flagClear;
    wire mapped;

    // one function judges whether a level change counts as a valid edge
    function edge_valid;
        input [1:0] sel;
        input prev;
        input cur;
        begin
            case (sel)
                `ACU_EDGE_BOTH: edge_valid = prev ^ cur;
                `ACU_EDGE_FALL: edge_valid = prev & ~cur;
                `ACU_EDGE_RISE: edge_valid = ~prev & cur;
                default: edge_valid = 1'b0; // reserved code flags nothing
            endcase
        end
    endfunction

    // apb decode; slave answers in the second access cycle, after one wait state
    assign access = psel & penable & ~pready;
    assign wrEn = access & pwrite & pstrb[0];
    assign mapped = (paddr == `ACU_ADDR_CTRL_STATUS) ||
        (paddr == `ACU_ADDR_INPUT_SEL) ||
        (paddr == `ACU_ADDR_REF_GEN) ||
        (paddr == `ACU_ADDR_PIN_EN);

    // only a real edge of the enabled comparator, seen in run mode, counts
    assign validEdge = compareEnable &
        edge_valid(edgeSelect_r, prevLevel_r, level_r);
    assign flagClear = wrEn && (paddr == `ACU_ADDR_CTRL_STATUS) &&
        !pwdata[`ACU_CS_EDGE_FLAG];

    // read mux over the low byte; upper bits read as zero
    always @* begin
        readByte = `ACU_RST_BYTE;
        case (paddr)
            `ACU_ADDR_CTRL_STATUS: begin
                readByte[`ACU_CS_CMP_EN] = compareEnable;
                readByte[`ACU_CS_EDGE_FLAG] = edgeFlag_r;
                readByte[`ACU_CS_IRQ_EN] = edgeIrqEnable_r;
                readByte[`ACU_CS_LEVEL] = level_r;
                readByte[`ACU_CS_OUT_PIN_EN] = outputPinEnable_r;
                readByte[1:0] = edgeSelect_r;
            end
            `ACU_ADDR_INPUT_SEL: begin
                readByte[6:4] = plusInputSelect;
                readByte[2:0] = minusInputSelect;
            end
            `ACU_ADDR_REF_GEN: begin
                readByte[`ACU_RG_EN] = refGenEnable;
                readByte[`ACU_RG_SRC] = refSourceSelect;
                readByte[4:0] = refLevelCode;
            end
            `ACU_ADDR_PIN_EN: readByte[6:0] = inputPinEnables;
            default: readByte = `ACU_RST_BYTE;
        endcase
    end

    // apb answer registers
    always @(posedge clk) begin
        if (reset) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= access;
            pslverr <= access & ~mapped;
            if (access && !pwrite) begin
                prdata <= {24'h000000, readByte};
            end
        end
    end

    // control registers; controls of generator and comparator never
    // interlock, software owns the sequencing between them
    always @(posedge clk) begin
        if (reset) begin
            compareEnable <= 1'b0;
            edgeIrqEnable_r <= 1'b0;
            outputPinEnable_r <= 1'b0;
            edgeSelect_r <= `ACU_EDGE_BOTH;
            plusInputSelect <= 3'h0;
            minusInputSelect <= 3'h0;
            refGenEnable <= 1'b0;
            refSourceSelect <= 1'b0;
            refLevelCode <= 5'h00;
            inputPinEnables <= `ACU_RST_PINS;
        end else if (wrEn) begin
            case (paddr)
                `ACU_ADDR_CTRL_STATUS: begin
                    compareEnable <= pwdata[`ACU_CS_CMP_EN];
                    edgeIrqEnable_r <= pwdata[`ACU_CS_IRQ_EN];
                    outputPinEnable_r <= pwdata[`ACU_CS_OUT_PIN_EN];
                    edgeSelect_r <= pwdata[1:0];
                end
                `ACU_ADDR_INPUT_SEL: begin
                    plusInputSelect <= pwdata[6:4];
                    minusInputSelect <= pwdata[2:0];
                end
                `ACU_ADDR_REF_GEN: begin
                    refGenEnable <= pwdata[`ACU_RG_EN];
                    refSourceSelect <= pwdata[`ACU_RG_SRC];
                    refLevelCode <= pwdata[4:0];
                end
                `ACU_ADDR_PIN_EN: begin
                    inputPinEnables <= pwdata[6:0];
                end
                default: ;
            endcase
        end
    end

    // two-stage synchroniser, then level and previous value for edges.
    // in stop the level register is not updated while the clock runs, so the level simply holds
    // and catches up at the first edges after wakeup
    always @(posedge clk) begin
        if (reset) begin
            syncA_r <= 1'b0;
            syncB_r <= 1'b0;
            level_r <= 1'b0;
            prevLevel_r <= 1'b0;
        end else begin
            syncA_r <= compareRaw;
            syncB_r <= syncA_r;
            if (!stopMode) begin
                level_r <= compareEnable & syncB_r;
            end
            prevLevel_r <= level_r;
        end
    end

    // sticky edge flag; a new edge wins over a clear in the same cycle
    always @(posedge clk) begin
        if (reset) begin
            edgeFlag_r <= 1'b0;
        end else if (validEdge) begin
            edgeFlag_r <= 1'b1;
        end else if (flagClear) begin
            edgeFlag_r <= 1'b0;
        end
    end

    // interrupt, wakeup and pin outputs, all registered
    always @(posedge clk) begin
        if (reset) begin
            edgeIrq <= 1'b0;
            stopWakeIrq <= 1'b0;
            comparePinOut <= 1'b0;
            comparePinOe <= 1'b0;
        end else begin
            edgeIrq <= edgeFlag_r & edgeIrqEnable_r;
            // synchronised edge seen while stopped, before the level catches up;
            // it stays until software clears the flag or disables the comparator
            stopWakeIrq <= compareEnable & (stopMode | stopWakeIrq) &
                (edge_valid(edgeSelect_r, level_r, syncB_r) |
                stopWakeIrq) & ~flagClear;
            comparePinOut <= level_r;
            comparePinOe <= outputPinEnable_r;
        end
    end

endmodule // acu_compare_ctrl
`default_nettype wire

// ### design/acu_consts.vh
/*
 * constants for the analog compare unit control: register offsets,
 * field positions and reset values. assumes inclusion by bare name.
 */
`ifndef ACU_CONSTS_VH
`define ACU_CONSTS_VH

// register indexes; byte address is four times the index
`define ACU_IDX_CTRL_STATUS 4'h0
`define ACU_IDX_INPUT_SEL 4'h1
`define ACU_IDX_REF_GEN 4'h2
`define ACU_IDX_PIN_EN 4'h3
`define ACU_ADDR_CTRL_STATUS 12'h000
`define ACU_ADDR_INPUT_SEL 12'h004
`define ACU_ADDR_REF_GEN 12'h008
`define ACU_ADDR_PIN_EN 12'h00C

// control and status register fields
`define ACU_CS_EDGE_SEL_LO 0
`define ACU_CS_EDGE_SEL_HI 1
`define ACU_CS_OUT_PIN_EN 2
`define ACU_CS_LEVEL 3
`define ACU_CS_IRQ_EN 4
`define ACU_CS_EDGE_FLAG 6
`define ACU_CS_CMP_EN 7

// edge select codes
`define ACU_EDGE_BOTH 2'h0
`define ACU_EDGE_FALL 2'h1
`define ACU_EDGE_RISE 2'h2

// input select fields
`define ACU_SEL_MINUS_LO 0
`define ACU_SEL_PLUS_LO 4

// reference generator fields
`define ACU_RG_LEVEL_LO 0
`define ACU_RG_SRC 6
`define ACU_RG_EN 7

// reset values
`define ACU_RST_BYTE 8'h00
`define ACU_RST_PINS 7'h00

`endif

// ### test/acu_analog_model.sv
/* behavioural analog core: pads, reference generator and comparator.
   assumes 5-bit pad levels from the bench and the unit's steering ports. */
`timescale 1ns/1ps
`default_nettype none
module acu_analog_model (
    input wire logic [34:0] extLevels,
    input wire logic [6:0] pinEn,
    input wire logic genEn,
    input wire logic [4:0] genCode,
    input wire logic [2:0] plusSel,
    input wire logic [2:0] minusSel,
    output logic rawOut
);
    // a blocked pad reads ground, so a missing enable shows as a wrong result
    function automatic logic [5:0] lv(input logic [2:0] s);
        if (s == 3'h7) return genEn ? 6'(genCode) + 6'h01 : 6'h00;
        return pinEn[s] ? 6'(extLevels[s * 5 +: 5]) : 6'h00;
    endfunction
    // any pair of the eight sources can be compared
    always_comb rawOut = lv(plusSel) > lv(minusSel);
endmodule // acu_analog_model
`default_nettype wire

// ### test/acu_compare_chk.sv
/* port checker for the compare unit control.
   assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module acu_compare_chk (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic compareRaw,
    input wire logic stopMode,
    input wire logic compareEnable,
    input wire logic refGenEnable,
    input wire logic comparePinOut,
    input wire logic comparePinOe,
    input wire logic edgeIrq,
    input wire logic stopWakeIrq
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    property p_rst; $fell(reset) |-> !(compareEnable | refGenEnable);
    endproperty
    a_rst: assert property (p_rst) else $error("unit on after reset");
    property p_off; !compareEnable [*3] |-> !comparePinOut; endproperty
    a_off: assert property (p_off) else $error("level while off");
    property p_sync; (compareEnable && !stopMode && $stable(compareRaw)) [*6]
        |-> comparePinOut == compareRaw; endproperty
    a_sync: assert property (p_sync) else $error("level lost");
    property p_frz; (stopMode && $stable(compareEnable)) [*3]
        |-> $stable(comparePinOut); endproperty
    a_frz: assert property (p_frz) else $error("level moved in stop");
    property p_wake; $rose(stopWakeIrq) |-> $past(stopMode); endproperty
    a_wake: assert property (p_wake) else $error("wake outside stop");
    property p_irq; $fell(edgeIrq) |-> $past(psel && pwrite)
        || $past(psel && pwrite, 2); endproperty
    a_irq: assert property (p_irq) else $error("irq fell alone");
    property p_oe; $changed(comparePinOe) |-> $past(psel && pwrite)
        || $past(psel && pwrite, 2); endproperty
    a_oe: assert property (p_oe) else $error("pin enable moved alone");
    property p_err; psel && penable && !pready && paddr > 12'h00C
        |=> pready && pslverr; endproperty
    a_err: assert property (p_err) else $error("unmapped not refused");
    // main scenarios
    c_irq: cover property ($rose(edgeIrq));
    c_wake: cover property ($rose(stopWakeIrq));
    c_err: cover property (pslverr);
endmodule // acu_compare_chk
bind acu_compare_ctrl acu_compare_chk chk_u (.clk, .reset, .psel, .penable,
    .pwrite, .paddr, .pready, .pslverr, .compareRaw, .stopMode, .compareEnable,
    .refGenEnable, .comparePinOut, .comparePinOe, .edgeIrq, .stopWakeIrq);
`default_nettype wire

// ### test/acu_compare_ctrl_tb.sv
/* self-checking bench for the compare unit control with an analog model.
   assumes an apb slave that answers after its own wait state. */
`timescale 1ns/1ps
`default_nettype none
module acu_compare_ctrl_tb;
    logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, stopMode = 0;
    logic compareRaw, pready, pslverr, compareEnable, refGenEnable;
    logic refSourceSelect, comparePinOut, comparePinOe, edgeIrq, stopWakeIrq;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata;
    logic [34:0] extLv = 35'h0;
    logic [2:0] plusInputSelect, minusInputSelect;
    logic [6:0] inputPinEnables;
    logic [4:0] refLevelCode;
    logic [32:0] expQ[$];
    logic [7:0] v[4];
    logic [7:0] msk[4] = '{8'hD7, 8'h77, 8'hDF, 8'h7F};
    logic [7:0] ex;
    int errCount = 0, checked = 0, i;
    always #2.5 clk = ~clk;
    acu_compare_ctrl dut_u (.clk, .reset, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb(4'hF), .prdata, .pready, .pslverr, .compareRaw,
        .stopMode, .compareEnable, .plusInputSelect, .minusInputSelect,
        .inputPinEnables, .refGenEnable, .refSourceSelect, .refLevelCode,
        .comparePinOut, .comparePinOe, .edgeIrq, .stopWakeIrq);
    acu_analog_model core_u (.extLevels(extLv), .pinEn(inputPinEnables),
        .genEn(refGenEnable), .genCode(refLevelCode), .plusSel(plusInputSelect),
        .minusSel(minusInputSelect), .rawOut(compareRaw));
    task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
        checked++;
        if (got !== exp) begin
            errCount++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one transfer; upper data bits are random since only the low byte counts
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
            input logic [8:0] e);
        int n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= ($urandom() & 32'hFFFFFF00) | {24'h000000, d};
        if (!w) expQ.push_back({e[8], 24'h000000, e[7:0]});
        @(posedge clk);
        penable <= 1'b1;
        do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
        if (n == 20) errCount++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // read answers are matched against the oldest note
    always @(posedge clk) begin
        if (pready === 1'b1 && !pwrite) cmp({pslverr, prdata}, expQ.pop_front());
    end
    // main sequence
    initial begin
        void'($urandom(1));
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        for (i = 0; i < 5; i++) apb(1'b0, 12'(i * 4), 8'h00, {i == 4, 8'h00});
        for (i = 1; i < 4; i++) begin
            v[i] = 8'($urandom());
            apb(1'b1, 12'(i * 4), v[i], 9'h000);
            apb(1'b0, 12'(i * 4), 8'h00, {1'b0, v[i] & msk[i]});
        end
        cmp({13'h0, plusInputSelect, minusInputSelect, inputPinEnables,
            refGenEnable, refSourceSelect, refLevelCode}, {13'h0, v[1][6:4],
            v[1][2:0], v[3][6:0], v[2][7:6], v[2][4:0]});
        // software opens the pad and settles the generator before enabling
        apb(1'b1, 12'h00C, 8'h01, 9'h000);
        apb(1'b1, 12'h008, 8'h0F, 9'h000);
        apb(1'b1, 12'h008, 8'h8F, 9'h000);
        apb(1'b1, 12'h004, 8'h07, 9'h000);
        for (i = 0; i < 4; i++) begin
            apb(1'b1, 12'h000, 8'h90 | 8'(i), 9'h000);
            extLv[4:0] <= 5'h1F;
            repeat (8) @(posedge clk);
            ex = 8'h98 | 8'(i) | ((i == 0 || i == 2) ? 8'h40 : 8'h00);
            apb(1'b0, 12'h000, 8'h00, {1'b0, ex});
            cmp({32'h0, edgeIrq}, {32'h0, ex[6]});
            apb(1'b1, 12'h000, 8'h90 | 8'(i), 9'h000);
            extLv[4:0] <= 5'h00;
            repeat (8) @(posedge clk);
            ex = 8'h90 | 8'(i) | (i < 2 ? 8'h40 : 8'h00);
            apb(1'b0, 12'h000, 8'h00, {1'b0, ex});
        end
        apb(1'b1, 12'h000, 8'h84, 9'h000);
        extLv[4:0] <= 5'h1F;
        repeat (8) @(posedge clk);
        cmp({30'h0, comparePinOe, comparePinOut, edgeIrq}, 33'h6);
        apb(1'b1, 12'h000, 8'h90, 9'h000);
        stopMode <= 1'b1;
        extLv[4:0] <= 5'h00;
        repeat (8) @(posedge clk);
        cmp({31'h0, stopWakeIrq, comparePinOut}, 33'h3);
        stopMode <= 1'b0;
        repeat (8) @(posedge clk);
        apb(1'b0, 12'h000, 8'h00, 9'h0D0);
        end_sim;
    end
    // a hang counts as a failure
    initial begin
        #100000;
        errCount++;
        end_sim;
    end
    task automatic end_sim;
        $display("checked %0d errors %0d", checked, errCount);
        if (errCount == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
endmodule // acu_compare_ctrl_tb
`default_nettype wire
